// file: include/bmd_pkg.sv
// Shared constants and carrier types for the bus matrix decoder.
// Assumes a single clock domain and SystemVerilog-2012 tools.
package bmd_pkg;

	// ==========================================================
	// Port counts and numbering.
	localparam int NUM_MASTERS = 4;
	localparam int NUM_SLAVES  = 5;
	localparam logic [2:0] SLV_SRAM   = 3'h0;
	localparam logic [2:0] SLV_ROM    = 3'h1;
	localparam logic [2:0] SLV_FLASH  = 3'h2;
	localparam logic [2:0] SLV_EXTBUS = 3'h3;
	localparam logic [2:0] SLV_BRIDGE = 3'h4;
	localparam logic [2:0] SLV_NONE   = 3'h7;
	localparam logic [1:0] MST_CPU_ID  = 2'h0;
	localparam logic [1:0] MST_CPU_SYS = 2'h1;
	localparam logic [1:0] MST_DMA     = 2'h2;
	localparam logic [1:0] MST_CRC     = 2'h3;

	// ==========================================================
	// Wired paths: bit m of entry s is set when master m reaches slave s.
	localparam logic [3:0] PATH_SRAM   = 4'he;
	localparam logic [3:0] PATH_ROM    = 4'hd;
	localparam logic [3:0] PATH_FLASH  = 4'h9;
	localparam logic [3:0] PATH_EXTBUS = 4'he;
	localparam logic [3:0] PATH_BRIDGE = 4'h6;

	// ==========================================================
	// Address map, identical for every master.
	localparam logic [11:0] SRAM_BASE_HI   = 12'h200;
	localparam logic [6:0]  SRAM_ALIAS_HI  = 7'h11;
	localparam logic [11:0] PERI_BASE_HI   = 12'h400;
	localparam logic [6:0]  PERI_ALIAS_HI  = 7'h21;
	localparam logic [9:0]  ROM_BASE_HI    = 10'h002;
	localparam logic [9:0]  FLASH_BASE_HI  = 10'h001;
	localparam logic [3:0]  EXTBUS_BASE_HI = 4'h6;

	// ==========================================================
	// Arbitration overhead in master clock cycles for the DMA master.
	localparam int DMA_M2P_CYCLES = 1;
	localparam int DMA_P2M_CYCLES = 2;

	// ==========================================================
	// Carriers.
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic [31:0] wdata;
		logic        periToMem;
	} bmd_mreq_s;

	typedef struct packed {
		logic        done;
		logic        err;
		logic [31:0] rdata;
	} bmd_mrsp_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        write;
		logic [31:0] wdata;
		logic        bitOp;
		logic [2:0]  bitIdx;
		logic [1:0]  master;
	} bmd_sreq_s;

	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} bmd_srsp_s;

	typedef struct packed {
		logic [2:0]  slave;
		logic        bitOp;
		logic [2:0]  bitIdx;
		logic [31:0] addr;
	} bmd_dec_s;

	// Decode one address; alias hits are folded onto one bit of the region.
	function automatic bmd_dec_s bmdDecode(input logic [31:0] a);
		bmd_dec_s r;
		r.slave  = SLV_NONE;
		r.bitOp  = 1'b0;
		r.bitIdx = a[4:2];
		r.addr   = a;
		if (a[31:20] == SRAM_BASE_HI) begin
			r.slave = SLV_SRAM;
		end else if (a[31:25] == SRAM_ALIAS_HI) begin
			r.slave = SLV_SRAM;
			r.bitOp = 1'b1;
			r.addr  = {SRAM_BASE_HI, a[24:5]};
		end else if (a[31:20] == PERI_BASE_HI) begin
			r.slave = SLV_BRIDGE;
		end else if (a[31:25] == PERI_ALIAS_HI) begin
			r.slave = SLV_BRIDGE;
			r.bitOp = 1'b1;
			r.addr  = {PERI_BASE_HI, a[24:5]};
		end else if (a[31:22] == ROM_BASE_HI) begin
			r.slave = SLV_ROM;
		end else if (a[31:22] == FLASH_BASE_HI) begin
			r.slave = SLV_FLASH;
		end else if (a[31:28] == EXTBUS_BASE_HI) begin
			r.slave = SLV_EXTBUS;
		end
		return r;
	endfunction

	// Wired-path table lookup.
	function automatic logic [3:0] bmdPaths(input logic [2:0] s);
		case (s)
			SLV_SRAM:   return PATH_SRAM;
			SLV_ROM:    return PATH_ROM;
			SLV_FLASH:  return PATH_FLASH;
			SLV_EXTBUS: return PATH_EXTBUS;
			SLV_BRIDGE: return PATH_BRIDGE;
			default:    return 4'h0;
		endcase
	endfunction

endpackage

// file: rtl/bmd_arbiter.sv
// Round-robin arbiter for one slave port of the matrix.
// Assumes requesters hold their request until the slave signals done.
`timescale 1ns/1ps
`default_nettype none
module bmd_arbiter
	import bmd_pkg::*;
#(
	parameter int N = 4
) (
	// Clock and reset.
	input  wire logic         clock,
	input  wire logic         rst_n,
	// Requests and completion.
	input  wire logic [N-1:0] req,
	input  wire logic         done,
	// Registered grant.
	output logic      [N-1:0] grant
);
	localparam int IW = $clog2(N);

	typedef struct packed {
		logic          busy;
		logic [IW-1:0] owner;
	} bmd_arb_s;

	bmd_arb_s q, d;

	// ==========================================================
	// Grant is taken from the state, so every new owner costs one cycle.
	always_comb begin
		logic [N-1:0] live;
		logic         found;
		logic [IW-1:0] idx;
		d     = q;
		live  = req;
		found = 1'b0;
		idx   = '0;
		if (q.busy && (done || !req[q.owner])) begin
			d.busy = 1'b0;
			live[q.owner] = 1'b0; // Finished owner must not win again at once.
		end
		if (!d.busy) begin
			for (int i = 1; i <= N; i++) begin
				idx = IW'((int'(q.owner) + i) % N);
				if (!found && live[idx]) begin
					found   = 1'b1;
					d.busy  = 1'b1;
					d.owner = idx;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign grant = q.busy ? (N'(1) << q.owner) : '0;

	// ==========================================================
	a_grant_onehot: assert property (@(posedge clock) disable iff (!rst_n)
		$onehot0(grant)) else $error("More than one master granted.");
	a_grant_fair: assert property (@(posedge clock) disable iff (!rst_n)
		(q.busy && done && (req & ~grant) != '0) |=> (grant != $past(grant)) && (grant != '0))
		else $error("Waiting master skipped by round robin.");

endmodule
`default_nettype wire

// file: rtl/bmd_matrix.sv
// Bus matrix decoder: four masters, five slaves, one arbiter per slave.
// Assumes masters hold a request until done, and slaves pulse ready once.
`timescale 1ns/1ps
`default_nettype none
module bmd_matrix
	import bmd_pkg::*;
(
	// Master clock and reset.
	input  wire logic      clock,
	input  wire logic      rst_n,
	// Master ports.
	input  wire bmd_mreq_s mReq [NUM_MASTERS],
	output bmd_mrsp_s      mRsp [NUM_MASTERS],
	// Slave ports.
	output bmd_sreq_s      sReq [NUM_SLAVES],
	input  wire bmd_srsp_s sRsp [NUM_SLAVES]
);

	typedef struct packed {
		logic [NUM_MASTERS-1:0] pend;
		logic [NUM_MASTERS-1:0] hold;
		logic [NUM_MASTERS-1:0] err;
	} bmd_state_s;

	bmd_state_s q, d;
	bmd_dec_s   dec     [NUM_MASTERS];
	logic [NUM_MASTERS-1:0] reachOk;
	logic [NUM_MASTERS-1:0] arbReq [NUM_SLAVES];
	logic [NUM_MASTERS-1:0] grant  [NUM_SLAVES];
	logic [NUM_MASTERS-1:0] doneM;

	// ==========================================================
	// Per-master decoders, all the same map.
	// The path row is copied into a local word before one bit is picked out.
	// A select taken straight off a function result is not portable.
	always_comb begin
		logic [NUM_MASTERS-1:0] wired;
		wired = '0;
		for (int m = 0; m < NUM_MASTERS; m++) begin
			dec[m]     = bmdDecode(mReq[m].addr);
			wired      = bmdPaths(dec[m].slave);
			reachOk[m] = (dec[m].slave != SLV_NONE) && wired[m];
		end
	end

	// ==========================================================
	// Arbiter requests: a master joins only after its overhead hold ends.
	always_comb begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			for (int m = 0; m < NUM_MASTERS; m++) begin
				arbReq[s][m] = q.pend[m] && !q.hold[m] && reachOk[m] &&
					(dec[m].slave == 3'(s));
			end
		end
	end

	// One independent arbiter per slave; unwired masters never request it.
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : gArb
		bmd_arbiter #(
			.N     (NUM_MASTERS)
		) uArb (
			.clock (clock),
			.rst_n (rst_n),
			.req   (arbReq[s] & bmdPaths(3'(s))),
			.done  (sRsp[s].ready),
			.grant (grant[s])
		);
	end

	// ==========================================================
	// Slave side: mux the granted master onto the slave port.
	always_comb begin
		for (int s = 0; s < NUM_SLAVES; s++) begin
			sReq[s] = '0;
			for (int m = 0; m < NUM_MASTERS; m++) begin
				if (grant[s][m]) begin
					sReq[s].valid  = 1'b1;
					sReq[s].addr   = dec[m].addr;
					sReq[s].write  = mReq[m].write;
					sReq[s].wdata  = mReq[m].wdata;
					sReq[s].bitOp  = dec[m].bitOp;
					sReq[s].bitIdx = dec[m].bitIdx;
					sReq[s].master = 2'(m);
				end
			end
		end
	end

	// ==========================================================
	// Master side: completion from the granted slave or from the error path.
	always_comb begin
		for (int m = 0; m < NUM_MASTERS; m++) begin
			mRsp[m] = '0;
			doneM[m] = 1'b0;
			for (int s = 0; s < NUM_SLAVES; s++) begin
				if (grant[s][m] && sRsp[s].ready) begin
					doneM[m]      = 1'b1;
					mRsp[m].rdata = sRsp[s].rdata;
					mRsp[m].err   = sRsp[s].err;
				end
			end
			if (q.err[m]) begin
				mRsp[m].err = 1'b1;
			end
			mRsp[m].done = doneM[m] || q.err[m];
		end
	end

	// ==========================================================
	// Request tracking; the extra hold cycle models the slower DMA direction.
	// A refused request raises err for one cycle only; while err stands the
	// still-held valid is not taken again, so one request gives one answer.
	always_comb begin
		d = q;
		for (int m = 0; m < NUM_MASTERS; m++) begin
			d.err[m]  = 1'b0;
			d.hold[m] = 1'b0;
			if (doneM[m] || q.err[m]) begin
				d.pend[m] = 1'b0;
			end else if (mReq[m].valid && !q.pend[m]) begin
				if (reachOk[m]) begin
					d.pend[m] = 1'b1;
					d.hold[m] = (2'(m) == MST_DMA) && mReq[m].periToMem &&
						(DMA_P2M_CYCLES > DMA_M2P_CYCLES);
				end else begin
					d.err[m] = 1'b1;
				end
			end
		end
	end

	// Everything here and in the bridge runs on the one master clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Checks.
	a_unwired_err: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[0].valid && !q.pend[0] && !q.err[0] && mReq[0].addr[31:20] == SRAM_BASE_HI)
		|=> mRsp[0].done && mRsp[0].err) else $error("Code master reached SRAM.");
	a_crc_bridge: assert property (@(posedge clock) disable iff (!rst_n)
		grant[SLV_BRIDGE][MST_CRC] == 1'b0) else $error("CRC master granted the bridge.");
	a_dma_flash: assert property (@(posedge clock) disable iff (!rst_n)
		grant[SLV_FLASH][MST_DMA] == 1'b0) else $error("DMA master granted Flash.");
	a_dma_m2p: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[2].valid && !q.pend[2] && !mReq[2].periToMem && reachOk[2] && !q.err[2])
		##1 (arbReq[dec[2].slave] == 4'h4 && grant[dec[2].slave] == '0)
		|=> grant[dec[2].slave][2])
		else $error("DMA memory-to-peripheral grant not after one cycle.");
	a_dma_p2m: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[2].valid && !q.pend[2] && mReq[2].periToMem && reachOk[2] && !q.err[2])
		|=> (q.hold[2] && !arbReq[dec[2].slave][2]) ##1 arbReq[dec[2].slave][2])
		else $error("DMA peripheral-to-memory overhead not two cycles.");
	a_rom_map: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[3].addr[31:22] == ROM_BASE_HI) |-> dec[3].slave == SLV_ROM)
		else $error("ROM address not decoded to ROM.");
	a_alias_bit: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[1].addr[31:25] == SRAM_ALIAS_HI) |->
		(dec[1].bitOp && dec[1].addr == {SRAM_BASE_HI, mReq[1].addr[24:5]}
		&& dec[1].bitIdx == mReq[1].addr[4:2])) else $error("SRAM alias misdecoded.");
	a_peri_alias: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[2].addr[31:25] == PERI_ALIAS_HI) |-> dec[2].slave == SLV_BRIDGE && dec[2].bitOp)
		else $error("Peripheral alias misdecoded.");
	a_same_map: assert property (@(posedge clock) disable iff (!rst_n)
		(mReq[0].addr == mReq[3].addr) |-> dec[0] == dec[3])
		else $error("Decoders disagree on one address.");
	a_concurrent: assert property (@(posedge clock) disable iff (!rst_n)
		(arbReq[SLV_ROM] == 4'h1 && arbReq[SLV_SRAM] == 4'h2 && grant[SLV_ROM] == '0
		&& grant[SLV_SRAM] == '0) |=> grant[SLV_ROM][0] && grant[SLV_SRAM][1])
		else $error("Independent slaves not granted together.");

	// ==========================================================
	// Per-slave checks. A slave in wait states must see a frozen request,
	// or a slow slave could complete an access that nobody asked for.
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : gSlvChk
		a_slave_hold: assert property (@(posedge clock) disable iff (!rst_n)
			(sReq[s].valid && !sRsp[s].ready) |=> sReq[s].valid && $stable(sReq[s]))
			else $error("Slave request changed while stalled.");
		a_wired_only: assert property (@(posedge clock) disable iff (!rst_n)
			sReq[s].valid |-> (bmdPaths(3'(s)) & (4'h1 << sReq[s].master)) != 4'h0)
			else $error("Slave request from an unwired master.");
	end

	// ==========================================================
	// Per-master checks. A refused access answers once and only once, and an
	// idle master never sees a completion that belongs to someone else.
	for (genvar m = 0; m < NUM_MASTERS; m++) begin : gMstChk
		a_err_pulse: assert property (@(posedge clock) disable iff (!rst_n)
			q.err[m] |-> (mRsp[m].done && mRsp[m].err) ##1 !mRsp[m].done)
			else $error("Refused access not answered by a single error pulse.");
		a_idle_quiet: assert property (@(posedge clock) disable iff (!rst_n)
			(!q.pend[m] && !q.err[m]) |-> !mRsp[m].done)
			else $error("Completion seen by a master with nothing pending.");
	end

endmodule
`default_nettype wire

// file: verif/bmd_matrix_tb_top.sv
// Self-checking bench for the bus matrix decoder.
// Assumes the slave model answers all five slave ports.
`timescale 1ns/1ps
`default_nettype none
module bmd_matrix_tb_top
	import bmd_pkg::*;
;
	// ==========================================================
	// Bench state and expected map; bit s of a reach entry is slave s.
	localparam logic [31:0] BASE [NUM_SLAVES] = '{32'h2000_0000,
		32'h0080_0000, 32'h0040_0000, 32'h6000_0000, 32'h4000_0000};
	localparam logic [4:0]  REACH [NUM_MASTERS] = '{5'h06, 5'h19, 5'h1b, 5'h0f};
	logic        clock    = 1'b0;
	logic        rst_n    = 1'b0;
	logic        slowMode = 1'b0;
	logic [31:0] wrData   = 32'h0;
	bmd_mreq_s   mReq [NUM_MASTERS] = '{default: '0};
	bmd_mrsp_s   mRsp [NUM_MASTERS];
	bmd_sreq_s   sReq [NUM_SLAVES];
	bmd_srsp_s   sRsp [NUM_SLAVES];
	int          n_errors = 0;
	int          checked  = 0;
	int          lat [NUM_MASTERS];
	logic        err [NUM_MASTERS];
	logic [2:0]  sl [NUM_MASTERS];
	logic [31:0] rd [NUM_MASTERS];
	bmd_sreq_s   sq [NUM_MASTERS];

	bmd_matrix dut (.clock(clock), .rst_n(rst_n), .mReq(mReq), .mRsp(mRsp),
		.sReq(sReq), .sRsp(sRsp));
	bmd_slave_model slaves (.clock(clock), .rst_n(rst_n), .slowMode(slowMode),
		.sReq(sReq), .sRsp(sRsp));

	// Clock generator.
	initial begin
		forever #25 clock = ~clock;
	end

	// ==========================================================
	// Shared tasks.
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	// One access, a write when wrData is nonzero; the request stands until the edge after done is seen.
	task automatic doAccess(input int m, input logic [31:0] a, input logic p2m);
		lat[m] = 0;
		sl[m] = 3'h7;
		@(negedge clock);
		mReq[m] <= '{valid: 1'b1, addr: a, write: |wrData, wdata: wrData, periToMem: p2m};
		do begin
			@(negedge clock);
			lat[m]++;
			for (int s = 0; s < NUM_SLAVES; s++) begin
				if (sReq[s].valid === 1'b1 && sReq[s].master === 2'(m)) begin
					sl[m] = 3'(s);
					sq[m] = sReq[s];
				end
			end
		end while (mRsp[m].done !== 1'b1 && lat[m] < 40);
		chk(32'(lat[m] < 40), 32'h1);
		err[m] = mRsp[m].err;
		rd[m] = mRsp[m].rdata;
		@(negedge clock);
		mReq[m] <= '0;
	endtask

	// ==========================================================
	// Scenarios.
	task automatic t_paths();
		for (int m = 0; m < NUM_MASTERS; m++)
			for (int s = 0; s < NUM_SLAVES; s++) begin
				doAccess(m, BASE[s], 1'b0);
				chk(32'(err[m]), 32'(!REACH[m][s]));
				chk(32'(sl[m]), REACH[m][s] ? 32'(s) : 32'h7);
				if (REACH[m][s]) chk(rd[m], {3'(s), BASE[s][28:0]});
			end
	endtask

	task automatic t_alias();
		doAccess(1, 32'h2200_0234, 1'b0);
		chk(sq[1].addr, 32'h2000_0011);
		chk(32'({sq[1].bitOp, sq[1].bitIdx}), 32'hd);
		wrData = 32'h0000_00a5;
		doAccess(2, 32'h4200_0234, 1'b0);
		wrData = 32'h0;
		chk(sq[2].addr, 32'h4000_0011);
		chk(32'(sl[2]), 32'h4);
		chk(32'({sq[2].write, sq[2].bitOp, sq[2].wdata[7:0]}), 32'h3a5);
	endtask

	task automatic t_errdma();
		doAccess(3, 32'h1000_0000, 1'b0);
		chk(32'({err[3], 8'(lat[3])}), 32'h101);
		doAccess(2, BASE[4], 1'b0);
		chk(32'(lat[2]), 32'h2);
		doAccess(2, BASE[0], 1'b1);
		chk(32'(lat[2]), 32'h3);
	endtask

	// Four masters to four slaves must all finish in the minimum time.
	task automatic t_concurrent();
		fork
			doAccess(0, BASE[1], 1'b0);
			doAccess(1, BASE[0], 1'b0);
			doAccess(2, BASE[3], 1'b0);
			doAccess(3, BASE[2], 1'b0);
		join
		for (int m = 0; m < NUM_MASTERS; m++)
			chk(32'(lat[m]), 32'h2);
	endtask

	// Three masters on SRAM are served one after another.
	task automatic t_contend();
		fork
			doAccess(1, BASE[0], 1'b0);
			doAccess(2, BASE[0] + 32'h4, 1'b0);
			doAccess(3, BASE[0] + 32'h8, 1'b0);
		join
		chk(32'((1 << lat[1]) | (1 << lat[2]) | (1 << lat[3])), 32'h1c);
	endtask

	task automatic t_slow();
		@(negedge clock);
		slowMode <= 1'b1;
		doAccess(0, BASE[2], 1'b0);
		chk(32'(lat[0]), 32'h5);
		chk(rd[0], {3'h2, BASE[2][28:0]});
		slowMode <= 1'b0;
	endtask

	task automatic end_of_test();
		if (n_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence and watchdog; the run needs well under 1000 cycles.
	initial begin
		repeat (12) @(negedge clock);
		rst_n <= 1'b1;
		t_paths();
		t_alias();
		t_errdma();
		t_concurrent();
		t_contend();
		t_slow();
		end_of_test();
	end

	initial begin
		#(5000 * 50);
		n_errors++;
		end_of_test();
	end
endmodule
`default_nettype wire

// file: verif/bmd_slave_model.sv
// Behavioural model of the five slaves behind the bus matrix decoder.
// Assumes one access at a time per slave port and a shared master clock.
`timescale 1ns/1ps
`default_nettype none
module bmd_slave_model
	import bmd_pkg::*;
(
	// Clock, reset and pacing.
	input  wire logic      clock,
	input  wire logic      rst_n,
	input  wire logic      slowMode,
	// Slave ports.
	input  wire bmd_sreq_s sReq [NUM_SLAVES],
	output bmd_srsp_s      sRsp [NUM_SLAVES]
);
	// ==========================================================
	// Idle read data keeps moving so a stale value never looks right.
	logic [31:0] noise;

	// Free running pattern for the idle data lines.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			noise <= 32'h5a5a_a5a5;
		end else begin
			noise <= ~noise + 32'h0001_0003;
		end
	end

	// ==========================================================
	// Each slave answers at once, or after three waits in slow mode.
	for (genvar s = 0; s < NUM_SLAVES; s++) begin : g_slv
		logic       hit;
		logic [1:0] waitCnt;
		assign hit = sReq[s].valid && (!slowMode || waitCnt == 2'h3);
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				waitCnt <= 2'h0;
			end else if (!sReq[s].valid || hit) begin
				waitCnt <= 2'h0;
			end else begin
				waitCnt <= waitCnt + 2'h1;
			end
		end
		// Read data names the slave, so a wrong route shows at the master.
		assign sRsp[s] = '{ready: hit, err: 1'b0,
			rdata: hit ? {3'(s), sReq[s].addr[28:0]} : noise};
	end
endmodule
`default_nettype wire
